//--- include/sfpw_pkg.sv
package sfpw_pkg;

  // ******************************************************
  // Opcodes and command widths
  // ******************************************************
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_DPP = 8'hA2;
  localparam logic [7:0] OP_XDPP = 8'hD2;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_XQPP = 8'h38;
  localparam logic [7:0] OP_CLRFLAG = 8'h50;
  localparam logic [2:0] LEN_MIN_PROG = 3'h5;
  localparam logic [2:0] LEN_ADDR_LAST = 3'h3;
  localparam logic [2:0] LEN_DATA = 3'h4;
  localparam logic [2:0] LEN_OPC = 3'h1;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_AW = 8;
  localparam int NUM_PAGES = 16;
  localparam int PG_AW = 4;
  localparam int PAGES_PER_SECT = 4;
  localparam int SECT_AW = 2;
  localparam int NUM_SECT = NUM_PAGES / PAGES_PER_SECT;

  // ******************************************************
  // Status and flag status bit positions
  // ******************************************************
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int FL_READY = 7;
  localparam int FL_ERASE_ERR = 5;
  localparam int FL_PROG_ERR = 4;
  localparam int FL_PROG_SUSP = 2;
  localparam int FL_PROT_ERR = 1;
  localparam logic [7:0] FL_ERR_MASK = 8'h32;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_MHZ = 40;
  localparam int PP_MAX_US = 10;

  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [1:0] {SFPW_EXT, SFPW_DUAL, SFPW_QUAD} sfpw_proto_e;

  // Frame summary held in the link domain, read by the core after select rises.
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic [2:0] len;
    logic aligned;
  } sfpw_frame_s;

endpackage

//--- logic/sfpw_core.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Opcode 50h clears erase, program, protection errors.
// - Select low starts command; lanes follow protocol.
// - Raising select anytime after the opcode byte ends flag clearing.
// - Misaligned end: no write, latch kept.
// - Address bits sampled on rising clock.
// - Protected target: skip, keep latch, flags 1,4.
// - Timeout clears latch, sets program error.
// - Programming only turns ones into zeros.
// - Decode 02h, A2h, D2h page writes.
// - Decode 32h, 38h quad page writes.
// - Write in progress high while programming.
// - Latch cleared when page write ends.
// - Status and flags readable during write.
// - Page write pausable and continuable.
// - Data past page end wraps within page.
// - Overflow keeps only last page of bytes.
// - Short write leaves other bytes untouched.
module sfpw_core
  import sfpw_pkg::*;
#(
  parameter logic [7:0] WREN_OP = 8'h06,
  parameter logic [7:0] SUSP_OP = 8'hB0,
  parameter logic [7:0] RESUME_OP = 8'h30,
  parameter int PP_MAX_CYC = PP_MAX_US * CLK_MHZ
) (
  // System clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial link.
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic [3:0] i_dq,
  // Configuration.
  input wire logic [1:0] i_proto,
  input wire logic [NUM_SECT-1:0] i_sect_prot,
  input wire logic i_cell_ready,
  // Array read port.
  input wire logic [PG_AW+PAGE_AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // Status view.
  output logic [7:0] o_status,
  output logic [7:0] o_flag_status
);

  // ******************************************************
  // Link domain
  // ******************************************************

  logic [7:0] sh_r;
  logic [2:0] bcnt_r;
  logic first_r;
  logic bsy_s1_r;
  logic bsy_s2_r;
  sfpw_frame_s frm_r;
  logic [PAGE_AW-1:0] dptr_r;
  logic [PAGE_BYTES-1:0] mask_r;
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic busy_r;

  // Lanes used in a phase: opcode, address or data.
  function automatic logic [2:0] lanes(input logic [1:0] proto, input logic [7:0] op, input logic [1:0] ph);
    logic [2:0] w;
    w = 3'h1;
    if (proto == SFPW_DUAL) begin
      w = 3'h2;
    end else if (proto == SFPW_QUAD) begin
      w = 3'h4;
    end else if (ph == 2'h1) begin
      w = (op == OP_XDPP) ? 3'h2 : (op == OP_XQPP) ? 3'h4 : 3'h1;
    end else if (ph == 2'h2) begin
      w = (op == OP_DPP || op == OP_XDPP) ? 3'h2 : (op == OP_QPP || op == OP_XQPP) ? 3'h4 : 3'h1;
    end
    return w;
  endfunction

  // Program opcode decode, shared by both domains.
  function automatic logic is_prog(input logic [7:0] op);
    return op == OP_PP || op == OP_DPP || op == OP_XDPP || op == OP_QPP || op == OP_XQPP;
  endfunction

  // Phase, lane width and the byte being assembled.
  wire [2:0] cur_len = first_r ? 3'h0 : frm_r.len;
  wire [1:0] phase = (cur_len == 3'h0) ? 2'h0 : (cur_len < LEN_DATA) ? 2'h1 : 2'h2;
  wire [2:0] width = lanes(i_proto, frm_r.op, phase);
  wire [7:0] sh_nxt = (width == 3'h4) ? {sh_r[3:0], i_dq[3:0]} :
                      (width == 3'h2) ? {sh_r[5:0], i_dq[1:0]} : {sh_r[6:0], i_dq[0]};
  wire [3:0] bsum = {1'b0, bcnt_r} + {1'b0, width};
  wire byte_done = bsum[3];
  wire [2:0] len_nxt = (cur_len == LEN_MIN_PROG) ? cur_len : cur_len + 3'h1;
  wire take_data = byte_done && cur_len >= LEN_DATA && is_prog(frm_r.op) && !bsy_s2_r;
  wire clr_mask = byte_done && cur_len == 3'h0 && is_prog(sh_nxt) && !bsy_s2_r;

  // Bit position and first-edge marker; select high holds them at frame start.
  always_ff @(posedge i_sck or posedge i_sel_n) begin
    if (i_sel_n) begin
      bcnt_r <= 3'h0;
      first_r <= 1'b1;
    end else begin
      bcnt_r <= bsum[2:0];
      first_r <= 1'b0;
    end
  end

  // Busy seen from the link; edges exist only inside frames, which is enough to gate the buffer.
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      bsy_s1_r <= 1'b0;
      bsy_s2_r <= 1'b0;
    end else begin
      bsy_s1_r <= busy_r;
      bsy_s2_r <= bsy_s1_r;
    end
  end

  // Shift, opcode, address and frame length, all on rising clock.
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      sh_r <= 8'h00;
      frm_r <= '0;
      dptr_r <= '0;
    end else begin
      sh_r <= sh_nxt;
      frm_r.aligned <= byte_done;
      if (first_r) begin
        frm_r.len <= byte_done ? LEN_OPC : 3'h0;
      end else if (byte_done) begin
        frm_r.len <= len_nxt;
      end
      if (byte_done && cur_len == 3'h0) begin
        frm_r.op <= sh_nxt;
      end
      if (byte_done && phase == 2'h1) begin
        frm_r.addr <= {frm_r.addr[15:0], sh_nxt};
      end
      if (byte_done && cur_len == LEN_ADDR_LAST) begin
        dptr_r <= sh_nxt;
      end else if (take_data) begin
        dptr_r <= dptr_r + 8'h01;
      end
    end
  end

  // Page buffer: later bytes overwrite earlier ones at the same offset.
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      mask_r <= '0;
    end else if (clr_mask) begin
      mask_r <= '0;
    end else if (take_data) begin
      mask_r[dptr_r] <= 1'b1;
    end
  end

  always_ff @(posedge i_sck) begin
    if (take_data) begin
      pbuf[dptr_r] <= sh_nxt;
    end
  end

  // ******************************************************
  // Core domain
  // ******************************************************

  typedef enum logic [1:0] {SFPW_IDLE, SFPW_PROG} sfpw_state_e;

  logic sel_s1_r;
  logic sel_s2_r;
  logic sel_s3_r;
  sfpw_state_e st_r;
  sfpw_state_e st_nxt;
  logic wel_r;
  logic susp_r;
  logic [7:0] flag_r;
  logic [PAGE_AW-1:0] idx_r;
  logic [PG_AW-1:0] pg_r;
  logic [15:0] wdog_r;
  logic [7:0] mem [0:NUM_PAGES*PAGE_BYTES-1];
  logic [NUM_PAGES*PAGE_BYTES-1:0] vld_r;

  // A cell not programmed since reset reads as erased; this spares a reset of the whole array.
  function automatic logic [7:0] cell_val(input logic vld, input logic [7:0] d);
    return vld ? d : 8'hFF;
  endfunction

  // Select crosses as a level; the frame summary is quiet once select is high.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sel_s3_r <= 1'b1;
    end else begin
      sel_s1_r <= i_sel_n;
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
    end
  end

  // Frame end decode.
  wire frame_end = sel_s2_r && !sel_s3_r;
  wire [PG_AW-1:0] tgt_pg = frm_r.addr[PG_AW+PAGE_AW-1:PAGE_AW];
  wire tgt_prot = i_sect_prot[tgt_pg[PG_AW-1:PG_AW-SECT_AW]];
  wire prog_cmd = frame_end && is_prog(frm_r.op) && frm_r.len == LEN_MIN_PROG;
  wire prog_ok = prog_cmd && frm_r.aligned && wel_r && st_r == SFPW_IDLE;
  wire start_prot = prog_ok && tgt_prot;
  wire start_run = prog_ok && !tgt_prot;
  wire cmd_done = frame_end && frm_r.len != 3'h0 && frm_r.aligned;
  wire clr_cmd = frame_end && frm_r.op == OP_CLRFLAG && frm_r.len != 3'h0;
  wire step = st_r == SFPW_PROG && !susp_r && i_cell_ready;
  wire last_step = step && idx_r == 8'hFF;
  wire expire = st_r == SFPW_PROG && !susp_r && wdog_r == 16'(PP_MAX_CYC);
  wire [PG_AW+PAGE_AW-1:0] mem_a = {pg_r, idx_r};
  wire [7:0] prog_byte = cell_val(vld_r[mem_a], mem[mem_a]) & pbuf[idx_r];

  // Program sequencer state.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SFPW_IDLE: begin
        if (start_run) begin
          st_nxt = SFPW_PROG;
        end
      end
      SFPW_PROG: begin
        if (last_step || expire) begin
          st_nxt = SFPW_IDLE;
        end
      end
      default: begin
        st_nxt = SFPW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= SFPW_IDLE;
      busy_r <= 1'b0;
      pg_r <= '0;
    end else begin
      st_r <= st_nxt;
      busy_r <= st_nxt == SFPW_PROG;
      if (start_run) begin
        pg_r <= tgt_pg;
      end
    end
  end

  // Byte index and watchdog; both freeze while paused.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idx_r <= '0;
      wdog_r <= '0;
    end else if (start_run) begin
      idx_r <= '0;
      wdog_r <= '0;
    end else if (st_r == SFPW_PROG && !susp_r) begin
      wdog_r <= wdog_r + 16'h0001;
      if (step) begin
        idx_r <= idx_r + 8'h01;
      end
    end
  end

  // Array update; unmarked bytes of the page are never touched.
  always_ff @(posedge i_clk) begin
    if (step && mask_r[idx_r]) begin
      mem[mem_a] <= prog_byte;
    end
  end

  // Written marks; reset returns every cell to the erased view.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vld_r <= '0;
    end else if (step && mask_r[idx_r]) begin
      vld_r[mem_a] <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= 8'hFF;
    end else begin
      o_rd_data <= cell_val(vld_r[i_rd_addr], mem[i_rd_addr]);
    end
  end

  // Write enable latch; the ending of a write wins over anything else.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wel_r <= 1'b0;
    end else if (last_step || expire) begin
      wel_r <= 1'b0;
    end else if (cmd_done && frm_r.op == WREN_OP) begin
      wel_r <= 1'b1;
    end
  end

  // Pause and continue are honoured only while a write runs.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      susp_r <= 1'b0;
    end else if (st_r != SFPW_PROG) begin
      susp_r <= 1'b0;
    end else if (cmd_done && frm_r.op == SUSP_OP) begin
      susp_r <= 1'b1;
    end else if (cmd_done && frm_r.op == RESUME_OP) begin
      susp_r <= 1'b0;
    end
  end

  // Error flags: a setting event beats a clear in the same cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_r <= 8'h00;
    end else begin
      if (clr_cmd) begin
        flag_r <= flag_r & ~FL_ERR_MASK;
      end
      if (start_prot) begin
        flag_r[FL_PROT_ERR] <= 1'b1;
        flag_r[FL_PROG_ERR] <= 1'b1;
      end
      if (expire) begin
        flag_r[FL_PROG_ERR] <= 1'b1;
      end
    end
  end

  // Status stays visible throughout a write so it can be polled.
  always_comb begin
    o_status = 8'h00;
    o_status[ST_WIP] = busy_r;
    o_status[ST_WEL] = wel_r;
    o_flag_status = flag_r;
    o_flag_status[FL_READY] = !busy_r;
    o_flag_status[FL_PROG_SUSP] = susp_r;
  end

  // ******************************************************
  // Checks
  // ******************************************************

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  clear_flags_a: assert property (clr_cmd && !expire |=> !flag_r[FL_ERASE_ERR] && !flag_r[FL_PROG_ERR] && !flag_r[FL_PROT_ERR])
    else $error("error flags not cleared");
  misalign_hold_a: assert property (prog_cmd && !frm_r.aligned && wel_r && !busy_r |=> wel_r && !busy_r && $stable(flag_r))
    else $error("misaligned write acted");
  protect_flags_a: assert property (start_prot |=> flag_r[FL_PROT_ERR] && flag_r[FL_PROG_ERR] && wel_r && !busy_r)
    else $error("protected write mishandled");
  timeout_fail_a: assert property (expire |=> !wel_r && flag_r[FL_PROG_ERR] && !busy_r)
    else $error("timeout not reported");
  wip_start_a: assert property (start_run |=> busy_r ##1 (busy_r && !o_flag_status[FL_READY]))
    else $error("write in progress not raised");
  wel_end_a: assert property ($fell(busy_r) |-> !wel_r)
    else $error("latch kept after write");
  pause_hold_a: assert property (susp_r && busy_r && !start_run |=> $stable(idx_r) && $stable(wdog_r))
    else $error("paused write advanced");
  wel_ignore_a: assert property (prog_cmd && !wel_r && !busy_r && !clr_cmd |=> !busy_r && $stable(flag_r))
    else $error("write without latch acted");

endmodule

//--- bench/sfpw_host.sv
`timescale 1ns/100ps
// ************************************************
// Serial host model, clock runs only inside frames
// ************************************************
module sfpw_host (
  // Lanes used for the opcode: 1, 2 or 4 as the protocol asks.
  input int i_ow,
  // Link pins.
  output logic o_sck,
  output logic o_sel_n,
  output logic [3:0] o_dq
);
  // Idle levels before the first frame.
  initial begin
    o_sck = 1'b0;
    o_sel_n = 1'b1;
    o_dq = 4'h0;
  end

  // Sends n groups of w bits, MSB first; lanes change while the clock is low.
  task automatic sh(input logic [7:0] b, input int w, input int n);
    for (int i = 0; i < n; i++) begin
      o_dq = 4'(b >> (8 - w * (i + 1)));
      #32 o_sck = 1'b1;
      #32 o_sck = 1'b0;
    end
  endtask

  // One frame; cut appends stray bits so that select rises inside a byte.
  task automatic frame(input logic [7:0] op, input int aw, input int dw, input logic [23:0] a,
                       input logic [7:0] d[$], input int cut);
    o_sel_n = 1'b0;
    #32;
    sh(op, i_ow, 8 / i_ow);
    if (aw > 0) begin
      for (int i = 2; i >= 0; i--) sh(a[8*i+:8], aw, 8 / aw);
    end
    foreach (d[i]) sh(d[i], dw, 8 / dw);
    if (cut > 0) sh(8'hA5, 1, cut);
    #32 o_sel_n = 1'b1;
    o_dq = ~o_dq;
    // The gap of 16 system cycles lets the core see select rise.
    #400;
  endtask
endmodule

//--- bench/test_sfpw_core.sv
`timescale 1ns/100ps
// ************************************************
// Bench for the page write and flag clear core
// ************************************************
module test_sfpw_core;
  import sfpw_pkg::*;
  localparam logic [7:0] WREN = 8'h06;
  localparam logic [7:0] SUSP = 8'hB0;
  localparam logic [7:0] RESM = 8'h30;
  logic i_clk, i_rst, sck, sel_n, cell_ready, chk_v, chk_d, kind;
  logic [3:0] dq, sect_prot;
  logic [1:0] proto;
  logic [11:0] rd_addr;
  logic [7:0] rd_data, status, flags;
  logic [15:0] got;
  logic [15:0] exp_q[$];
  logic [7:0] mem[4096];
  logic [7:0] nul[$];
  logic [7:0] one[$];
  logic [7:0] ops[6] = '{OP_PP, OP_DPP, OP_XDPP, OP_QPP, OP_XQPP, OP_PP};
  int aws[6] = '{1, 1, 2, 1, 4, 1};
  int dws[6] = '{1, 2, 2, 4, 4, 1};
  int errors, num_checks, ow;

  sfpw_host u_host (.i_ow(ow), .o_sck(sck), .o_sel_n(sel_n), .o_dq(dq));

  sfpw_core #(.WREN_OP(WREN), .SUSP_OP(SUSP), .RESUME_OP(RESM), .PP_MAX_CYC(300)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_sel_n(sel_n), .i_dq(dq), .i_proto(proto),
    .i_sect_prot(sect_prot), .i_cell_ready(cell_ready), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .o_status(status), .o_flag_status(flags));

  // System clock of 25 ns.
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Read data is registered, so a result is judged two edges after its request.
  always @(posedge i_clk) begin
    chk_d <= chk_v;
    if (chk_d) begin
      got = kind ? {status, flags} : {8'h00, rd_data};
      num_checks++;
      if (got !== exp_q[0]) begin
        errors++;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end

  // Queues one expectation: kind 1 is status and flags, kind 0 an array byte.
  task automatic chk(input logic k, input logic [11:0] a, input logic [15:0] e);
    @(posedge i_clk);
    kind <= k;
    rd_addr <= a;
    chk_v <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_clk);
    chk_v <= 1'b0;
    @(posedge i_clk);
  endtask

  // Bounded wait for the write in progress bit to drop.
  task automatic settle();
    for (int i = 0; i < 1000 && status[0] !== 1'b0; i++) @(posedge i_clk);
  endtask

  task automatic cmp_page(input int pg);
    for (int i = 0; i < 256; i++) chk(1'b0, 12'(pg * 256 + i), {8'h00, mem[pg * 256 + i]});
  endtask

  // Page write of n bytes from off; the model applies bytes in order so later ones win.
  task automatic pw(input int k, input int pg, input int off, input int n);
    logic [7:0] d[$];
    logic [7:0] pb[256];
    for (int i = 0; i < 256; i++) pb[i] = 8'hFF;
    for (int i = 0; i < n; i++) begin
      d.push_back(8'($urandom));
      pb[(off + i) % 256] = d[i];
    end
    u_host.frame(WREN, 0, 1, 0, nul, 0);
    u_host.frame(ops[k], aws[k], dws[k], {12'h000, 4'(pg), 8'(off)}, d, 0);
    chk(1'b1, 12'h000, 16'h0300);
    settle();
    chk(1'b1, 12'h000, 16'h0080);
    for (int i = 0; i < 256; i++) mem[pg * 256 + i] &= pb[i];
    cmp_page(pg);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    errors = 0;
    num_checks = 0;
    chk_v = 1'b0;
    chk_d = 1'b0;
    kind = 1'b0;
    rd_addr = 12'h000;
    proto = 2'h0;
    sect_prot = 4'h0;
    cell_ready = 1'b1;
    ow = 1;
    i_rst = 1'b1;
    one = '{8'h5A};
    foreach (mem[i]) mem[i] = 8'hFF;
    void'($urandom(32'hF7C3C313));
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk(1'b1, 12'h000, 16'h0080);
    u_host.frame(OP_PP, 1, 1, 24'h000010, one, 0);
    chk(1'b1, 12'h000, 16'h0080);
    cmp_page(0);
    $display("test latch clear done");
    for (int k = 0; k < 6; k++) pw(k, (k % 5) + 1, 252, 6);
    $display("test opcodes done");
    // Dual and quad protocols carry every phase, opcode included, on two or four lanes.
    proto <= 2'h1;
    ow = 2;
    pw(2, 7, 0, 3);
    proto <= 2'h2;
    ow = 4;
    pw(4, 8, 128, 4);
    proto <= 2'h0;
    ow = 1;
    $display("test protocols done");
    pw(3, 6, 16, 258);
    $display("test overflow done");
    sect_prot <= 4'h8;
    u_host.frame(WREN, 0, 1, 0, nul, 0);
    u_host.frame(OP_PP, 1, 1, 24'h000C00, one, 0);
    chk(1'b1, 12'h000, 16'h0292);
    u_host.frame(OP_PP, 1, 1, 24'h000C00, one, 3);
    chk(1'b1, 12'h000, 16'h0292);
    cmp_page(12);
    u_host.frame(OP_CLRFLAG, 0, 1, 0, nul, 3);
    chk(1'b1, 12'h000, 16'h0280);
    sect_prot <= 4'h0;
    $display("test protect done");
    cell_ready <= 1'b0;
    u_host.frame(OP_PP, 1, 1, 24'h000D00, one, 0);
    settle();
    chk(1'b1, 12'h000, 16'h0090);
    cell_ready <= 1'b1;
    u_host.frame(OP_CLRFLAG, 0, 1, 0, nul, 0);
    chk(1'b1, 12'h000, 16'h0080);
    $display("test timeout done");
    u_host.frame(WREN, 0, 1, 0, nul, 0);
    u_host.frame(OP_PP, 1, 1, 24'h000E00, one, 0);
    u_host.frame(SUSP, 0, 1, 0, nul, 0);
    repeat (300) @(posedge i_clk);
    chk(1'b1, 12'h000, 16'h0304);
    u_host.frame(RESM, 0, 1, 0, nul, 0);
    settle();
    chk(1'b1, 12'h000, 16'h0080);
    mem[14 * 256] = 8'h5A;
    cmp_page(14);
    $display("test pause done");
    results();
  end

  // Watchdog, well beyond the expected length of the run.
  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    results();
  end
endmodule
